// file: include/amd_pkg.sv
// Purpose: Shared types and constants of the addressing mode decoder.
// Assumes: Byte-wide memory, 16-bit addresses, 8-bit index registers.
// Notes: Modes are ordered by family; the family table lives in amd_mode_info.

package amd_pkg;

    // =====================================================================
    // Modes and families
    // =====================================================================
    typedef enum logic [4:0] {
        MD_INH, MD_IMM, MD_DIR_S, MD_DIR_L, MD_IDX_N, MD_IDX_S, MD_IDX_L,
        MD_IND_S, MD_IND_L, MD_INX_S, MD_INX_L, MD_REL_D, MD_REL_I,
        MD_BIT_D, MD_BIT_I, MD_BTR_D, MD_BTR_I
    } amd_mode_t;

    typedef enum logic [2:0] {
        FAM_INH, FAM_IMM, FAM_DIR, FAM_IDX, FAM_IND, FAM_REL, FAM_BIT
    } amd_family_t;

    // =====================================================================
    // Counts and fixed values
    // =====================================================================
    localparam int AMD_MODE_COUNT = 17;
    localparam int AMD_FAMILY_COUNT = 7;
    localparam logic [7:0] AMD_ZP_HIGH = 8'h00;
    localparam logic [15:0] AMD_ADDR_RST = 16'h0000;
    localparam logic [7:0] AMD_BYTE_RST = 8'h00;
    localparam logic [2:0] AMD_OPCODE_LEN = 3'h1;
    localparam logic [2:0] AMD_PREBYTE_LEN = 3'h1;
    localparam logic [1:0] AMD_CNT_NONE = 2'h0;
    localparam logic [1:0] AMD_CNT_BYTE = 2'h1;
    localparam logic [1:0] AMD_CNT_WORD = 2'h2;
    localparam logic [15:0] AMD_SHORT_IDX_MAX = 16'h01FE;
    localparam int AMD_REL_MIN = -128;
    localparam int AMD_REL_MAX = 127;

    // =====================================================================
    // Carriers
    // =====================================================================
    typedef struct packed {
        amd_mode_t mode;
        logic use_y;
        logic rmw;
        logic [15:0] opc_addr;
        logic [7:0] idx_x;
        logic [7:0] idx_y;
    } amd_req_t;

    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] target;
        logic [15:0] next_pc;
        logic [7:0] opnd;
        logic [2:0] len;
        amd_family_t family;
        logic illegal;
    } amd_res_t;

endpackage : amd_pkg

// file: src/amd_mode_info.sv
// Purpose: Per-mode table of fetched bytes, pointer size and family.
// Assumes: Purely combinational, read by the decoder sequencer.
// Notes: A long mode is one that carries a full 16-bit address or pointer.
`timescale 1ns/1ps
`default_nettype none

module amd_mode_info (
    input wire amd_pkg::amd_mode_t mode,
    output logic [1:0] fetch_n,
    output logic [1:0] ptr_n,
    output amd_pkg::amd_family_t family,
    output logic is_long
);
    import amd_pkg::*;

    always_comb begin
        fetch_n = AMD_CNT_NONE;
        ptr_n = AMD_CNT_NONE;
        family = FAM_INH;
        is_long = 1'b0;
        case (mode)
            MD_INH: family = FAM_INH;
            MD_IMM: begin
                fetch_n = AMD_CNT_BYTE;
                family = FAM_IMM;
            end
            MD_DIR_S: begin
                fetch_n = AMD_CNT_BYTE;
                family = FAM_DIR;
            end
            MD_DIR_L: begin
                fetch_n = AMD_CNT_WORD;
                family = FAM_DIR;
                is_long = 1'b1;
            end
            MD_IDX_N: family = FAM_IDX;
            MD_IDX_S: begin
                fetch_n = AMD_CNT_BYTE;
                family = FAM_IDX;
            end
            MD_IDX_L: begin
                fetch_n = AMD_CNT_WORD;
                family = FAM_IDX;
                is_long = 1'b1;
            end
            MD_IND_S, MD_INX_S: begin
                fetch_n = AMD_CNT_BYTE;
                ptr_n = AMD_CNT_BYTE;
                family = FAM_IND;
            end
            MD_IND_L, MD_INX_L: begin
                fetch_n = AMD_CNT_BYTE;
                ptr_n = AMD_CNT_WORD;
                family = FAM_IND;
                is_long = 1'b1;
            end
            MD_REL_D: begin
                fetch_n = AMD_CNT_BYTE;
                family = FAM_REL;
            end
            MD_REL_I: begin
                fetch_n = AMD_CNT_BYTE;
                ptr_n = AMD_CNT_BYTE;
                family = FAM_REL;
            end
            MD_BIT_D: begin
                fetch_n = AMD_CNT_BYTE;
                family = FAM_BIT;
            end
            MD_BIT_I: begin
                fetch_n = AMD_CNT_BYTE;
                ptr_n = AMD_CNT_BYTE;
                family = FAM_BIT;
            end
            MD_BTR_D: begin
                fetch_n = AMD_CNT_WORD;
                family = FAM_BIT;
            end
            MD_BTR_I: begin
                fetch_n = AMD_CNT_WORD;
                ptr_n = AMD_CNT_BYTE;
                family = FAM_BIT;
            end
            default: family = FAM_INH;
        endcase
    end

endmodule : amd_mode_info

`default_nettype wire

// file: src/amd_ea_adder.sv
// Purpose: Index and displacement adders of the decoder.
// Assumes: Index is unsigned, displacement is two's complement.
// Notes: The sums wrap within the 16-bit space.
`timescale 1ns/1ps
`default_nettype none

module amd_ea_adder (
    input wire logic [15:0] base,
    input wire logic [7:0] idx,
    input wire logic add_idx,
    input wire logic [15:0] pc,
    input wire logic [7:0] disp,
    output logic [15:0] ea,
    output logic [15:0] target
);
    import amd_pkg::*;

    wire [15:0] idx_ext = add_idx ? {AMD_ZP_HIGH, idx} : AMD_ADDR_RST;
    wire [15:0] disp_ext = {{8{disp[7]}}, disp};

    assign ea = base + idx_ext;
    assign target = pc + disp_ext;

endmodule : amd_ea_adder

`default_nettype wire

// file: src/amd_decoder.sv
// Purpose: Addressing mode decoder: operand fetch, pointer read, address math.
// Assumes: Memory port answers each held request with a one-cycle MEM_ACK.
// Notes: START is taken only while idle; one result per request.
//
// Function
// - Seventeen addressing modes in seven families.
// - Short modes reach page zero; RMW short only.
// - Inherent instructions are one byte long, two with use_y set (prebyte).
// - Immediate: opcode then operand value byte.
// - Short direct: one address byte, page zero.
// - Long direct: two address bytes, full space.
// - Indexed address is unsigned index plus offset.
// - No-offset indexed: index alone addresses page zero.
// - Y no-offset indexed adds one byte.
// - Short indexed: one offset byte, up to 1FE.
// - Long indexed: two offset bytes plus index.
// - Short indirect: byte pointer in page zero.
// - Long indirect: word pointer in page zero.
// - Relative: signed displacement from next instruction.
`timescale 1ns/1ps
`default_nettype none

module amd_decoder (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic START,
    input wire amd_pkg::amd_req_t REQ,
    input wire logic MEM_ACK,
    input wire logic [7:0] MEM_RDATA,
    output logic BUSY,
    output logic MEM_REQ,
    output logic [15:0] MEM_ADDR,
    output logic DONE,
    output amd_pkg::amd_res_t RESULT
);
    import amd_pkg::*;

    // =====================================================================
    // State and registers
    // =====================================================================
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_PTR, ST_CALC} amd_state_t;

    amd_state_t st_reg;
    amd_state_t st_next;
    amd_req_t req_reg;
    logic [7:0] b0_reg;
    logic [7:0] b1_reg;
    logic [7:0] p0_reg;
    logic [7:0] p1_reg;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic mem_req_reg;
    logic busy_reg;
    logic [15:0] mem_addr_reg;
    logic [15:0] mem_addr_next;
    logic done_reg;
    amd_res_t res_reg;

    // =====================================================================
    // Mode table and address math
    // =====================================================================
    logic [1:0] fetch_n;
    logic [1:0] ptr_n;
    amd_family_t family;
    logic is_long;

    amd_mode_info u_info (
        .mode(req_reg.mode),
        .fetch_n(fetch_n),
        .ptr_n(ptr_n),
        .family(family),
        .is_long(is_long)
    );

    // Start-time view of the table, so the first phase is chosen on START.
    logic [1:0] start_fetch_n;

    amd_mode_info u_start_info (
        .mode(REQ.mode),
        .fetch_n(start_fetch_n),
        .ptr_n(),
        .family(),
        .is_long()
    );

    amd_mode_t md;
    assign md = req_reg.mode;

    wire sel_zp_b0 = (md == MD_DIR_S) || (md == MD_IDX_S) || (md == MD_BIT_D)
        || (md == MD_BTR_D);
    wire sel_word_b = (md == MD_DIR_L) || (md == MD_IDX_L);
    wire sel_zp_p0 = (md == MD_IND_S) || (md == MD_INX_S) || (md == MD_BIT_I)
        || (md == MD_BTR_I);
    wire sel_word_p = (md == MD_IND_L) || (md == MD_INX_L);
    wire add_idx = (md == MD_IDX_N) || (md == MD_IDX_S) || (md == MD_IDX_L)
        || (md == MD_INX_S) || (md == MD_INX_L);
    wire [7:0] idx_sel = req_reg.use_y ? req_reg.idx_y : req_reg.idx_x;

    wire [15:0] base = sel_zp_b0 ? {AMD_ZP_HIGH, b0_reg}
        : sel_word_b ? {b0_reg, b1_reg}
        : sel_zp_p0 ? {AMD_ZP_HIGH, p0_reg}
        : sel_word_p ? {p0_reg, p1_reg}
        : AMD_ADDR_RST;

    wire [7:0] disp = (md == MD_REL_D) ? b0_reg
        : (md == MD_REL_I) ? p0_reg
        : ((md == MD_BTR_D) || (md == MD_BTR_I)) ? b1_reg
        : AMD_BYTE_RST;

    // The program counter already points past this instruction.
    wire [15:0] next_pc = req_reg.opc_addr + {13'h0000, AMD_OPCODE_LEN}
        + {14'h0000, fetch_n};

    // A prebyte precedes Y-based and indirect forms.
    wire use_pre = req_reg.use_y || (ptr_n != AMD_CNT_NONE);
    wire [2:0] len = AMD_OPCODE_LEN + {1'b0, fetch_n}
        + (use_pre ? AMD_PREBYTE_LEN : 3'h0);

    logic [15:0] ea;
    logic [15:0] target;

    amd_ea_adder u_adder (
        .base(base),
        .idx(idx_sel),
        .add_idx(add_idx),
        .pc(next_pc),
        .disp(disp),
        .ea(ea),
        .target(target)
    );

    // =====================================================================
    // Sequencer
    // =====================================================================
    wire last_fetch = (cnt_reg + 2'h1) == fetch_n;
    wire last_ptr = (cnt_reg + 2'h1) == ptr_n;
    wire [15:0] ptr_base = {AMD_ZP_HIGH, b0_reg};

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        mem_addr_next = mem_addr_reg;
        case (st_reg)
            ST_IDLE: begin
                cnt_next = AMD_CNT_NONE;
                if (START) begin
                    mem_addr_next = REQ.opc_addr + 16'h0001;
                    st_next = (start_fetch_n == AMD_CNT_NONE) ? ST_CALC
                        : ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (MEM_ACK) begin
                    cnt_next = cnt_reg + 2'h1;
                    mem_addr_next = mem_addr_reg + 16'h0001;
                    if (last_fetch) begin
                        cnt_next = AMD_CNT_NONE;
                        mem_addr_next = ptr_base;
                        if (cnt_reg == AMD_CNT_NONE) begin
                            mem_addr_next = {AMD_ZP_HIGH, MEM_RDATA};
                        end
                        st_next = (ptr_n != AMD_CNT_NONE) ? ST_PTR : ST_CALC;
                    end
                end
            end
            ST_PTR: begin
                if (MEM_ACK) begin
                    cnt_next = cnt_reg + 2'h1;
                    // Pointer bytes stay in page zero.
                    mem_addr_next = {AMD_ZP_HIGH, mem_addr_reg[7:0] + 8'h01};
                    if (last_ptr) begin
                        st_next = ST_CALC;
                    end
                end
            end
            ST_CALC: st_next = ST_IDLE;
            default: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_reg <= ST_IDLE;
            cnt_reg <= AMD_CNT_NONE;
            mem_addr_reg <= AMD_ADDR_RST;
            mem_req_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            mem_addr_reg <= mem_addr_next;
            mem_req_reg <= (st_next == ST_FETCH) || (st_next == ST_PTR);
            busy_reg <= (st_next != ST_IDLE);
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            req_reg <= '0;
            b0_reg <= AMD_BYTE_RST;
            b1_reg <= AMD_BYTE_RST;
            p0_reg <= AMD_BYTE_RST;
            p1_reg <= AMD_BYTE_RST;
        end else begin
            if (st_reg == ST_IDLE && START) begin
                req_reg <= REQ;
            end
            if (st_reg == ST_FETCH && MEM_ACK && cnt_reg == AMD_CNT_NONE) begin
                b0_reg <= MEM_RDATA;
            end
            if (st_reg == ST_FETCH && MEM_ACK && cnt_reg == AMD_CNT_BYTE) begin
                b1_reg <= MEM_RDATA;
            end
            if (st_reg == ST_PTR && MEM_ACK && cnt_reg == AMD_CNT_NONE) begin
                p0_reg <= MEM_RDATA;
            end
            if (st_reg == ST_PTR && MEM_ACK && cnt_reg == AMD_CNT_BYTE) begin
                p1_reg <= MEM_RDATA;
            end
        end
    end

    // =====================================================================
    // Result
    // =====================================================================
    // Read-modify-write instructions accept only the short forms.
    wire illegal = req_reg.rmw && is_long;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            done_reg <= 1'b0;
            res_reg <= '0;
        end else begin
            done_reg <= (st_reg == ST_CALC);
            if (st_reg == ST_CALC) begin
                res_reg.ea <= ea;
                res_reg.target <= target;
                res_reg.next_pc <= next_pc;
                res_reg.opnd <= b0_reg;
                res_reg.len <= len;
                res_reg.family <= family;
                res_reg.illegal <= illegal;
            end
        end
    end

    assign BUSY = busy_reg;
    assign MEM_REQ = mem_req_reg;
    assign MEM_ADDR = mem_addr_reg;
    assign DONE = done_reg;
    assign RESULT = res_reg;

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_inh_len: assert property ((st_reg == ST_CALC && md == MD_INH) |=> DONE && RESULT.len == 3'h1)
        else $error("Inherent length is not one byte.");

    chk_imm_opnd: assert property (DONE && md == MD_IMM |-> RESULT.opnd == b0_reg
        && RESULT.len == 3'h2 && RESULT.family == FAM_IMM)
        else $error("Immediate operand or length wrong.");

    chk_dir_short: assert property (DONE && md == MD_DIR_S |-> RESULT.ea == {8'h00, b0_reg})
        else $error("Short direct address wrong.");

    chk_dir_long: assert property (DONE && md == MD_DIR_L && !req_reg.use_y
        |-> RESULT.ea == {b0_reg, b1_reg} && RESULT.len == 3'h3)
        else $error("Long direct address or length wrong.");

    chk_idx_none: assert property (DONE && md == MD_IDX_N |-> RESULT.ea == {8'h00, idx_sel}
        && RESULT.len == (req_reg.use_y ? 3'h2 : 3'h1))
        else $error("No-offset indexed address or length wrong.");

    chk_idx_short: assert property (DONE && md == MD_IDX_S |-> RESULT.ea <= AMD_SHORT_IDX_MAX
        && RESULT.ea == {8'h00, b0_reg} + {8'h00, idx_sel})
        else $error("Short indexed address wrong.");

    chk_idx_long: assert property (DONE && md == MD_IDX_L
        |-> RESULT.ea == {b0_reg, b1_reg} + {8'h00, idx_sel})
        else $error("Long indexed address wrong.");

    chk_ind_short: assert property (DONE && md == MD_IND_S |-> RESULT.ea == {8'h00, p0_reg})
        else $error("Short indirect address wrong.");

    chk_ind_word: assert property (DONE && md == MD_IND_L |-> RESULT.ea == {p0_reg, p1_reg})
        else $error("Long indirect pointer order wrong.");

    chk_rel_reach: assert property (DONE && md == MD_REL_D
        |-> $signed(RESULT.target - RESULT.next_pc) >= AMD_REL_MIN
        && $signed(RESULT.target - RESULT.next_pc) <= AMD_REL_MAX
        && RESULT.next_pc == req_reg.opc_addr + 16'h0002)
        else $error("Relative target out of reach.");

    chk_rmw_short: assert property (DONE && req_reg.rmw |-> RESULT.illegal == ((md == MD_DIR_L)
        || (md == MD_IDX_L) || (md == MD_IND_L) || (md == MD_INX_L)))
        else $error("Long form not flagged for read-modify-write.");

    chk_mem_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("Memory request dropped before its answer.");

    chk_ptr_page: assert property ((st_reg == ST_PTR) |-> MEM_ADDR[15:8] == 8'h00)
        else $error("Pointer read left page zero.");

endmodule : amd_decoder

`default_nettype wire

// file: verif/amd_mem_model.sv
// Purpose: Program memory seen by the decoder's fetch port.
// Assumes: One byte per request, answered after a wait set by the bench.
// Notes: Out of reset, the data lines toggle whenever no answer is being given; reset holds them at zero.
`timescale 1ns/1ps
`default_nettype none

module amd_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic [3:0] lat,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [3:0] wait_reg;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end

    // =====================================================================
    // Answer logic
    // =====================================================================
    // The acknowledge cycle itself is skipped so that one request gets one answer.
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_ack <= 1'b0;
            wait_reg <= 4'h0;
            mem_rdata <= 8'h00;
        end else if (mem_req && !mem_ack && wait_reg >= lat) begin
            mem_ack <= 1'b1;
            wait_reg <= 4'h0;
            mem_rdata <= mem[mem_addr];
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule : amd_mem_model

`default_nettype wire

// file: verif/tb.sv
// Purpose: Self-checking bench of the addressing mode decoder.
// Assumes: Memory model answers with a latency set per scenario.
// Notes: Results are read at the clock edge that closes the DONE cycle.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import amd_pkg::*;
    logic CLK, SYS_RST, START, MEM_ACK, BUSY, MEM_REQ, DONE;
    amd_req_t REQ;
    logic [7:0] MEM_RDATA;
    logic [15:0] MEM_ADDR;
    amd_res_t RESULT;
    logic [3:0] mem_lat;
    int fails = 0;
    int checks_done = 0;
    int rd_cnt, req_cnt, n;

    amd_decoder u_amd_decoder (.CLK(CLK), .SYS_RST(SYS_RST), .START(START), .REQ(REQ), .MEM_ACK(MEM_ACK),
        .MEM_RDATA(MEM_RDATA), .BUSY(BUSY), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .DONE(DONE), .RESULT(RESULT));
    amd_mem_model u_amd_mem_model (.clk(CLK), .rst(SYS_RST), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR),
        .lat(mem_lat), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        if (MEM_ACK === 1'b1) rd_cnt++;
        if (MEM_REQ === 1'b1) req_cnt++;
    end

    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk

    // A second START during the request can be given to show it is ignored.
    task automatic run(input amd_mode_t m, input logic uy, input logic rw, input logic [15:0] opc,
                       input logic [7:0] x, input logic [7:0] y, input logic poke);
        @(posedge CLK);
        START <= 1'b1;
        REQ <= '{mode: m, use_y: uy, rmw: rw, opc_addr: opc, idx_x: x, idx_y: y};
        rd_cnt = 0;
        req_cnt = 0;
        @(posedge CLK);
        START <= poke;
        if (poke) REQ.mode <= MD_INH;
        n = 0;
        do begin
            @(posedge CLK);
            if (n == 0) chk(16'(BUSY), 16'h0001);
            START <= 1'b0;
            n++;
        end while (DONE !== 1'b1 && n < 300);
        if (n >= 300) chk(16'h0000, 16'h0001);
        chk(16'(BUSY), 16'h0000);
    endtask : run

    function automatic logic [15:0] sx(input logic [7:0] d);
        return {{8{d[7]}}, d};
    endfunction : sx

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_modes;
        int len_t [17] = '{1, 2, 2, 3, 1, 2, 3, 3, 3, 3, 3, 2, 3, 2, 3, 3, 4};
        int rd_t [17] = '{0, 1, 1, 2, 0, 1, 2, 2, 3, 2, 3, 1, 2, 1, 2, 2, 3};
        amd_family_t fam_t [17] = '{FAM_INH, FAM_IMM, FAM_DIR, FAM_DIR, FAM_IDX, FAM_IDX, FAM_IDX, FAM_IND,
            FAM_IND, FAM_IND, FAM_IND, FAM_REL, FAM_REL, FAM_BIT, FAM_BIT, FAM_BIT, FAM_BIT};
        for (int i = 0; i < 17; i++) begin
            run(amd_mode_t'(i), 1'b0, 1'b0, 16'h2000, 8'h10, 8'h20, 1'b0);
            chk(16'(RESULT.family), 16'(fam_t[i]));
            chk(16'(RESULT.len), 16'(len_t[i]));
            chk(16'(rd_cnt), 16'(rd_t[i]));
            chk(16'(RESULT.illegal), 16'h0000);
        end
    endtask : t_modes

    task automatic t_inherent;
        run(MD_INH, 1'b0, 1'b0, 16'h1234, 8'h00, 8'h00, 1'b0);
        chk(16'(n), 16'h0002);
        chk(16'(req_cnt), 16'h0000);
        chk(RESULT.next_pc, 16'h1235);
        run(MD_IDX_N, 1'b0, 1'b0, 16'h1234, 8'hFE, 8'h3C, 1'b0);
        chk(RESULT.ea, 16'h00FE);
        chk(16'(RESULT.len), 16'h0001);
        run(MD_IDX_N, 1'b1, 1'b0, 16'h1234, 8'hFE, 8'h3C, 1'b0);
        chk(RESULT.ea, 16'h003C);
        chk(16'(RESULT.len), 16'h0002);
    endtask : t_inherent

    task automatic t_direct;
        mem_lat = 4'h2;
        u_amd_mem_model.mem[16'h3001] = 8'hA7;
        u_amd_mem_model.mem[16'h4001] = 8'h12;
        u_amd_mem_model.mem[16'h4002] = 8'h34;
        u_amd_mem_model.mem[16'h5001] = 8'h55;
        run(MD_DIR_S, 1'b0, 1'b1, 16'h3000, 8'h00, 8'h00, 1'b0);
        chk(RESULT.ea, 16'h00A7);
        chk(RESULT.next_pc, 16'h3002);
        chk(16'(RESULT.illegal), 16'h0000);
        run(MD_DIR_L, 1'b0, 1'b1, 16'h4000, 8'h00, 8'h00, 1'b0);
        chk(RESULT.ea, 16'h1234);
        chk(16'(RESULT.illegal), 16'h0001);
        run(MD_IMM, 1'b0, 1'b0, 16'h5000, 8'h00, 8'h00, 1'b0);
        chk(16'(RESULT.opnd), 16'h0055);
        chk(16'(RESULT.len), 16'h0002);
    endtask : t_direct

    task automatic t_indexed;
        mem_lat = 4'h0;
        u_amd_mem_model.mem[16'h6001] = 8'hFF;
        u_amd_mem_model.mem[16'h7001] = 8'hFF;
        u_amd_mem_model.mem[16'h7002] = 8'hF0;
        run(MD_IDX_S, 1'b0, 1'b0, 16'h6000, 8'hFF, 8'h00, 1'b0);
        chk(RESULT.ea, 16'h01FE);
        run(MD_IDX_S, 1'b1, 1'b0, 16'h6000, 8'h01, 8'h80, 1'b0);
        chk(RESULT.ea, 16'h017F);
        chk(16'(RESULT.len), 16'h0003);
        run(MD_IDX_L, 1'b0, 1'b0, 16'h7000, 8'h20, 8'h00, 1'b0);
        chk(RESULT.ea, 16'h0010);
    endtask : t_indexed

    task automatic t_indirect;
        mem_lat = 4'h3;
        u_amd_mem_model.mem[16'h8001] = 8'h40;
        u_amd_mem_model.mem[16'h0040] = 8'h9C;
        u_amd_mem_model.mem[16'h9001] = 8'hFF;
        u_amd_mem_model.mem[16'h00FF] = 8'hAB;
        u_amd_mem_model.mem[16'h0000] = 8'hCD;
        run(MD_IND_S, 1'b0, 1'b0, 16'h8000, 8'h00, 8'h00, 1'b0);
        chk(RESULT.ea, 16'h009C);
        chk(16'(rd_cnt), 16'h0002);
        run(MD_IND_L, 1'b0, 1'b0, 16'h9000, 8'h00, 8'h00, 1'b0);
        chk(RESULT.ea, 16'hABCD);
        chk(16'(rd_cnt), 16'h0003);
    endtask : t_indirect

    task automatic t_relative;
        int extra;
        mem_lat = 4'h1;
        extra = 0;
        u_amd_mem_model.mem[16'hA001] = 8'h80;
        u_amd_mem_model.mem[16'hB001] = 8'h7F;
        run(MD_REL_D, 1'b0, 1'b0, 16'hA000, 8'h00, 8'h00, 1'b1);
        chk(RESULT.next_pc, 16'hA002);
        chk(RESULT.target, 16'hA002 + sx(8'h80));
        repeat (6) begin
            @(posedge CLK);
            if (DONE === 1'b1) extra++;
        end
        chk(16'(extra), 16'h0000);
        run(MD_REL_D, 1'b0, 1'b0, 16'hB000, 8'h00, 8'h00, 1'b0);
        chk(RESULT.target, 16'hB081);
    endtask : t_relative

    // A reset between requests clears the result and lets the next request start at once.
    task automatic t_reset;
        @(posedge CLK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        chk(RESULT.ea, 16'h0000);
        chk(16'({DONE, BUSY, MEM_REQ}), 16'h0000);
        run(MD_INH, 1'b0, 1'b0, 16'h0100, 8'h00, 8'h00, 1'b0);
        chk(16'(n), 16'h0002);
        chk(RESULT.next_pc, 16'h0101);
    endtask : t_reset

    // =====================================================================
    // Main sequence and watchdog
    // =====================================================================
    initial begin
        SYS_RST = 1'b1;
        START = 1'b0;
        REQ = '0;
        mem_lat = 4'h0;
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_modes();
        t_inherent();
        t_direct();
        t_indexed();
        t_indirect();
        t_relative();
        t_reset();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        end_sim();
    end
endmodule : tb

`default_nettype wire
